// >>> src/ssra_pkg.sv
// ssra_pkg: constants, types and helpers shared by the serial register slave
// assumes a byte-wide register port with 14-bit byte addresses
package ssra_pkg;

    localparam int unsigned DATA_W = 8;
    localparam int unsigned ADDR_W = 14;
    localparam int unsigned SYNC_W = 3;

    typedef logic [ADDR_W-1:0] ssra_addr_t;
    typedef logic [DATA_W-1:0] ssra_byte_t;

    // instruction codes
    localparam ssra_byte_t INSTR_READ  = 8'h0B;
    localparam ssra_byte_t INSTR_WRITE = 8'h02;

    // direction subfield codes, bits [15:14] of the address
    localparam logic [1:0] DIR_INC = 2'h0;
    localparam logic [1:0] DIR_RSV = 2'h1;
    localparam logic [1:0] DIR_DEC = 2'h2;
    localparam logic [1:0] DIR_FIX = 2'h3;

    // field positions inside the high address byte
    localparam int unsigned DIR_MSB = 7;
    localparam int unsigned DIR_LSB = 6;
    localparam int unsigned AHI_MSB = 5;

    // link-side counters and the core's address step
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] BIT_ONE  = 3'h1;
    localparam logic [1:0] HDR_DONE = 2'h3;
    localparam logic [1:0] BYTE_ONE = 2'h1;
    localparam ssra_addr_t ADDR_ONE = 14'h0001;

    // one-hot frame states of the core
    typedef enum logic [7:0] {
        ST_IDLE  = 8'h01,
        ST_SKIP  = 8'h02,
        ST_INSTR = 8'h04,
        ST_AHI   = 8'h08,
        ST_ALO   = 8'h10,
        ST_DUMMY = 8'h20,
        ST_WDATA = 8'h40,
        ST_RDATA = 8'h80
    } ssra_state_e;

    // address step between data bytes; wraps inside the 14-bit space
    function automatic ssra_addr_t ssra_step(input ssra_addr_t a,
                                             input logic [1:0] dir);
        ssra_addr_t r;
        if (dir == DIR_FIX) begin
            r = a;
        end else if (dir == DIR_DEC) begin
            r = a - ADDR_ONE;
        end else begin
            // increment, and the reserved code behaves the same
            r = a + ADDR_ONE;
        end
        return r;
    endfunction : ssra_step

endpackage : ssra_pkg

// >>> src/ssra_drv_if.sv
// ssra_drv_if: signals from the link and core to the serial output driver
// assumes tx_byte is held stable by the core while a load can occur
`timescale 1ns/10ps
interface ssra_drv_if;
    import ssra_pkg::*;
    logic       load;
    ssra_byte_t tx_byte;
    logic       serve;
    logic       hold;
    modport src (output load, output tx_byte, output serve, output hold);
    modport drv (input load, input tx_byte, input serve, input hold);
endinterface : ssra_drv_if

// >>> src/ssra_sync.sv
// ssra_sync: two-flop synchroniser for the select pin and link toggles
// assumes each input is a level or a toggle held for several clocks
`timescale 1ns/10ps
module ssra_sync (
    input  wire logic                       clk_i,
    input  wire logic                       resetn_i,
    input  wire logic                       ce_i,
    input  wire logic [ssra_pkg::SYNC_W-1:0] d_i,
    output wire logic [ssra_pkg::SYNC_W-1:0] q_o
);
    import ssra_pkg::*;

    typedef struct packed {
        logic [SYNC_W-1:0] s1;
        logic [SYNC_W-1:0] s2;
    } ssra_sync_s;

    ssra_sync_s q_q;
    ssra_sync_s q_d;

    always_comb begin
        q_d    = q_q;
        q_d.s1 = d_i;
        q_d.s2 = q_q.s1;
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            q_q <= '{default: '1};
        end else if (ce_i) begin
            q_q <= q_d;
        end
    end

    assign q_o = q_q.s2;

endmodule : ssra_sync

// >>> src/ssra_miso_drv.sv
// ssra_miso_drv: serial output shifter, launches on the falling link edge
// assumes load and the synced levels come from rising-edge link flops
`timescale 1ns/10ps
module ssra_miso_drv (
    input  wire logic   spi_clk_i,
    input  wire logic   spi_cs_n_i,
    ssra_drv_if.drv     dif,
    output wire logic   serial_out_o,
    output wire logic   serial_out_oe_n_o
);
    import ssra_pkg::*;

    typedef struct packed {
        logic [DATA_W-2:0] sh;
        logic              out;
        logic              oe_n;
        logic              held;
    } ssra_drv_s;

    localparam ssra_drv_s DRV_RST = '{oe_n: 1'b1, default: '0};

    ssra_drv_s q_q;
    ssra_drv_s q_d;

    always_comb begin
        q_d      = q_q;
        // once seen, the low hold lasts to the end of the frame
        q_d.held = q_q.held | dif.hold;
        if (q_d.held) begin
            q_d.out  = 1'b0; // R16
            q_d.oe_n = 1'b0; // R18
        end else if (dif.load && dif.serve) begin
            q_d.out  = dif.tx_byte[DATA_W-1]; // R20
            q_d.sh   = dif.tx_byte[DATA_W-2:0];
            q_d.oe_n = 1'b0;
        end else if (!q_q.oe_n) begin
            q_d.out = q_q.sh[DATA_W-2]; // R11
            q_d.sh  = {q_q.sh[DATA_W-3:0], 1'b0};
        end
    end

    // select high floats the pin at once, with no clock needed
    always_ff @(negedge spi_clk_i or posedge spi_cs_n_i) begin
        if (spi_cs_n_i) begin
            q_q <= DRV_RST; // R3 R21
        end else begin
            q_q <= q_d; // R2
        end
    end

    assign serial_out_o      = q_q.out;
    assign serial_out_oe_n_o = q_q.oe_n;

endmodule : ssra_miso_drv

// >>> src/ssra_slave.sv
// ssra_slave: four-wire serial slave giving a master byte access to the
// device registers, with wake and start-up gating
// assumes a byte register port whose read data is valid one clock after
// reg_rd_o, and power/init levels on the ref_clk_i domain
`timescale 1ns/10ps

// What this block does
// R1: frame runs from select fall to rise; clock may idle low or high.
// R2: input sampled on rising clock, output changed on falling clock.
// R3: with select high, pins are ignored and output floats.
// R4: first byte of every frame is the instruction from the master.
// R5: two address bytes follow: 14-bit byte address and 2-bit direction.
// R6: direction 00 increments, 10 decrements, 11 holds the address.
// R7: reserved direction 01 behaves exactly as increment.
// R8: read sends one ignored dummy byte, then data bytes return.
// R9: write data bytes follow the address directly, one or more.
// R10: output stays undriven during instruction, address and dummy bytes.
// R11: bytes msb first, high address byte first, order set by direction.
// R12: master uses only the read and write instruction codes.
// R13: pins ignored until init completes and select has risen once.
// R14: init finishing mid-frame changes nothing until select rises.
// R15: master's first access after init is a throwaway test read.
// R16: wake is per device; output held low while asleep and selected.
// R17: master polls the test register or waits for interrupt to see wake.
// R18: woken mid-frame, keep ignoring and hold output low until select rises.
// R19: after traffic, stay awake until the master allows sleep.
// R20: read data msb driven on falling edge after last dummy bit.
// R21: select rising ends a read and floats the output.
// R22: address steps near each output byte start, then next byte captured.
// R23: register value latched at the start of reading each byte.
// R24: a write commits only once the whole byte has arrived.
// R25: stepping wraps in the 14-bit space, direction kept.
module ssra_slave (
    input  wire logic                 ref_clk_i,
    input  wire logic                 resetn_i,
    input  wire logic                 ce_i,
    input  wire logic                 spi_clk_i,
    input  wire logic                 spi_cs_n_i,
    input  wire logic                 serial_in_pin_i,
    output wire logic                 serial_out_o,
    output wire logic                 serial_out_oe_n_o,
    input  wire logic                 init_done_i,
    input  wire logic                 awake_i,
    input  wire logic                 allow_sleep_i,
    output wire logic                 wake_req_o,
    output wire logic                 stay_awake_o,
    output wire ssra_pkg::ssra_addr_t reg_addr_o,
    output wire logic                 reg_rd_o,
    input  wire ssra_pkg::ssra_byte_t reg_rd_data_i,
    output wire logic                 reg_wr_o,
    output wire ssra_pkg::ssra_byte_t reg_wdata_o
);
    import ssra_pkg::*;

    // ---- link domain: rising-edge receive on the master's clock ----
    typedef struct packed {
        logic [2:0]        bits;
        logic [1:0]        bytes;
        logic [DATA_W-2:0] sh;
        ssra_byte_t        rx;
        logic              rx_t;
        logic              tk_t;
        logic              is_rd;
        logic              load;
        logic              srv1;
        logic              srv2;
        logic              hld1;
        logic              hld2;
    } ssra_link_s;

    // ---- core domain on ref_clk_i ----
    typedef struct packed {
        ssra_state_e st;
        logic        armed;
        logic        is_rd;
        logic        cs_d;
        logic        rx_d1;
        logic        rx_d2;
        logic        tk_d1;
        logic        tk_d2;
        logic        cap;
        logic        rd;
        logic        wr;
        logic        serve;
        logic        hold;
        logic        wake;
        logic        stay;
        logic [1:0]  dir;
        ssra_addr_t  addr;
        ssra_byte_t  wdata;
        ssra_byte_t  tx;
    } ssra_core_s;

    localparam ssra_link_s LINK_RST = '{default: '0};
    localparam ssra_core_s CORE_RST = '{st: ST_IDLE, cs_d: 1'b1,
                                        default: '0};

    ssra_link_s        lk_q;
    ssra_link_s        lk_d;
    ssra_core_s        co_q;
    ssra_core_s        co_d;
    ssra_byte_t        byte_in;
    logic [SYNC_W-1:0] sync_in;
    logic [SYNC_W-1:0] sync_out;
    logic              cs_s;
    logic              rx_s;
    logic              tk_s;
    logic              cs_fall;
    logic              cs_rise;
    logic              rx_new;
    logic              tk_new;

    ssra_drv_if dif ();

    // ---- link receive ----
    assign byte_in = {lk_q.sh, serial_in_pin_i};

    always_comb begin
        lk_d      = lk_q;
        lk_d.sh   = byte_in[DATA_W-2:0]; // R11
        lk_d.bits = lk_q.bits + BIT_ONE;
        lk_d.load = 1'b0;
        lk_d.srv1 = co_q.serve;
        lk_d.srv2 = lk_q.srv1;
        lk_d.hld1 = co_q.hold;
        lk_d.hld2 = lk_q.hld1;
        // toggle one clock after the load so the core never changes
        // tx while the falling edge is still picking it up
        if (lk_q.load) begin
            lk_d.tk_t = ~lk_q.tk_t; // R22
        end
        if (lk_q.bits == BIT_LAST) begin
            lk_d.rx   = byte_in; // R24
            lk_d.rx_t = ~lk_q.rx_t;
            if (lk_q.bytes == '0) begin
                lk_d.is_rd = (byte_in == INSTR_READ); // R4
            end
            if (lk_q.bytes == HDR_DONE) begin
                // dummy byte done, or a data byte done: load the next
                lk_d.load = lk_q.is_rd; // R8 R10 R20
            end else begin
                lk_d.bytes = lk_q.bytes + BYTE_ONE;
            end
        end
    end

    // select high is the frame's own reset; the clock may stop outside
    always_ff @(posedge spi_clk_i or posedge spi_cs_n_i) begin
        if (spi_cs_n_i) begin
            lk_q <= LINK_RST; // R1 R3
        end else begin
            lk_q <= lk_d; // R2
        end
    end

    assign dif.load    = lk_q.load;
    assign dif.tx_byte = co_q.tx;
    assign dif.serve   = lk_q.srv2;
    assign dif.hold    = lk_q.hld2;

    ssra_miso_drv u_drv (
        .spi_clk_i         (spi_clk_i),
        .spi_cs_n_i        (spi_cs_n_i),
        .dif               (dif),
        .serial_out_o      (serial_out_o),
        .serial_out_oe_n_o (serial_out_oe_n_o)
    );

    // ---- crossings into the core ----
    assign sync_in = {spi_cs_n_i, lk_q.rx_t, lk_q.tk_t};

    ssra_sync u_sync (
        .clk_i    (ref_clk_i),
        .resetn_i (resetn_i),
        .ce_i     (ce_i),
        .d_i      (sync_in),
        .q_o      (sync_out)
    );

    assign cs_s = sync_out[2];
    assign rx_s = sync_out[1];
    assign tk_s = sync_out[0];

    assign cs_fall = co_q.cs_d & ~cs_s;
    assign cs_rise = ~co_q.cs_d & cs_s;
    // toggles are looked at one clock late: the link clears them when
    // select rises, and that false edge must land after select is seen
    assign rx_new = (co_q.rx_d1 ^ co_q.rx_d2) & ~cs_s;
    assign tk_new = (co_q.tk_d1 ^ co_q.tk_d2) & ~cs_s;

    // ---- core frame logic ----
    always_comb begin
        co_d       = co_q;
        co_d.rd    = 1'b0;
        co_d.wr    = 1'b0;
        co_d.wake  = 1'b0;
        co_d.cap   = co_q.rd;
        co_d.cs_d  = cs_s;
        co_d.rx_d1 = rx_s;
        co_d.rx_d2 = co_q.rx_d1;
        co_d.tk_d1 = tk_s;
        co_d.tk_d2 = co_q.tk_d1;

        if (co_q.cap) begin
            co_d.tx = reg_rd_data_i; // R23
        end
        if (co_q.wr) begin
            co_d.addr = ssra_step(co_q.addr, co_q.dir); // R6 R7 R25
        end
        if (allow_sleep_i) begin
            co_d.stay = 1'b0;
        end
        if (!init_done_i) begin
            co_d.armed = 1'b0; // R13
        end

        if (cs_fall) begin
            if (co_q.armed && awake_i) begin
                co_d.st    = ST_INSTR; // R1 R4
                co_d.serve = 1'b1;
            end else begin
                co_d.st = ST_SKIP; // R13 R14 R18
            end
            // asleep but initialised: ask for wake and hold output low
            co_d.hold = co_q.armed & ~awake_i; // R16
            co_d.wake = co_q.armed & ~awake_i; // R16
            if (co_q.armed) begin
                co_d.stay = 1'b1; // R19
            end
        end else if (cs_rise) begin
            co_d.st    = ST_IDLE; // R21 R24
            co_d.serve = 1'b0;
            co_d.hold  = 1'b0;
            co_d.armed = init_done_i; // R13 R14
        end else begin
            unique case (co_q.st)
                ST_IDLE: begin
                end
                ST_SKIP: begin
                end
                ST_INSTR: begin
                    if (rx_new) begin
                        if (lk_q.rx == INSTR_READ) begin
                            co_d.is_rd = 1'b1;
                            co_d.st    = ST_AHI;
                        end else if (lk_q.rx == INSTR_WRITE) begin
                            co_d.is_rd = 1'b0;
                            co_d.st    = ST_AHI;
                        end else begin
                            // other codes: ignore the rest of the frame
                            co_d.st    = ST_SKIP;
                            co_d.serve = 1'b0;
                        end
                    end
                end
                ST_AHI: begin
                    if (rx_new) begin
                        co_d.dir  = lk_q.rx[DIR_MSB:DIR_LSB]; // R5
                        co_d.addr = {lk_q.rx[AHI_MSB:0],
                                     co_q.addr[DATA_W-1:0]}; // R11
                        co_d.st   = ST_ALO;
                    end
                end
                ST_ALO: begin
                    if (rx_new) begin
                        co_d.addr = {co_q.addr[ADDR_W-1:DATA_W],
                                     lk_q.rx}; // R5
                        if (co_q.is_rd) begin
                            co_d.rd = 1'b1; // R23
                            co_d.st = ST_DUMMY;
                        end else begin
                            co_d.st = ST_WDATA; // R9
                        end
                    end
                end
                ST_DUMMY: begin
                    if (rx_new) begin
                        co_d.st = ST_RDATA; // R8
                    end
                end
                ST_WDATA: begin
                    if (rx_new) begin
                        co_d.wr    = 1'b1; // R9 R24
                        co_d.wdata = lk_q.rx;
                    end
                end
                ST_RDATA: begin
                    // byte handed to the shifter: step and prefetch
                    if (tk_new) begin
                        co_d.addr = ssra_step(co_q.addr, co_q.dir); // R22
                        co_d.rd   = 1'b1; // R23
                    end
                end
            endcase
        end

        if (allow_sleep_i && !(cs_fall && co_q.armed)) begin
            co_d.stay = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            co_q <= CORE_RST;
        end else if (ce_i) begin
            co_q <= co_d;
        end
    end

    assign wake_req_o   = co_q.wake;
    assign stay_awake_o = co_q.stay;
    assign reg_addr_o   = co_q.addr;
    assign reg_rd_o     = co_q.rd;
    assign reg_wr_o     = co_q.wr;
    assign reg_wdata_o  = co_q.wdata;

endmodule : ssra_slave

// >>> sim/ssra_slave_sva.sv
// ssra_slave_sva: port-level checks on the serial register slave
// assumes the 40 MHz core clock and a link clock many times slower
`timescale 1ns/10ps
module ssra_slave_sva (
    input wire logic                 ref_clk_i,
    input wire logic                 resetn_i,
    input wire logic                 ce_i,
    input wire logic                 spi_clk_i,
    input wire logic                 spi_cs_n_i,
    input wire logic                 serial_in_pin_i,
    input wire logic                 serial_out_o,
    input wire logic                 serial_out_oe_n_o,
    input wire logic                 init_done_i,
    input wire logic                 awake_i,
    input wire logic                 allow_sleep_i,
    input wire logic                 wake_req_o,
    input wire logic                 stay_awake_o,
    input wire ssra_pkg::ssra_addr_t reg_addr_o,
    input wire logic                 reg_rd_o,
    input wire ssra_pkg::ssra_byte_t reg_rd_data_i,
    input wire logic                 reg_wr_o,
    input wire ssra_pkg::ssra_byte_t reg_wdata_o
);
    import ssra_pkg::*;
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!resetn_i);
    // a byte takes 40 core clocks, so 8 quiet ones is a safe floor
    sequence s_quiet8;
        (!reg_rd_o && !reg_wr_o) [*8];
    endsequence
    // long enough that no frame start is still in the synchroniser
    sequence s_sel_idle;
        spi_cs_n_i [*6];
    endsequence
    AST_RD_ONE: assert property (reg_rd_o |=> !reg_rd_o)
        else $error("read strobe wider than one cycle");
    AST_RD_ADDR: assert property (reg_rd_o |=> $stable(reg_addr_o))
        else $error("address moved under a read");
    AST_WR_GAP: assert property (reg_wr_o |=> s_quiet8)
        else $error("register strobes closer than a byte");
    AST_FLOAT_IDLE: assert property (spi_cs_n_i [*2] |-> serial_out_oe_n_o)
        else $error("data out driven while deselected");
    AST_UNINIT: assert property (!init_done_i |-> !reg_rd_o && !reg_wr_o)
        else $error("register access before init");
    AST_WAKE_ONE: assert property (wake_req_o |=> !wake_req_o)
        else $error("wake request wider than one cycle");
    AST_WAKE_QUIET: assert property (wake_req_o |=> s_quiet8)
        else $error("register access in a wake frame");
    AST_WAKE_STAY: assert property (wake_req_o |-> ##[0:2] stay_awake_o)
        else $error("wake frame did not hold the device awake");
    AST_STAY_HOLD: assert property (stay_awake_o && !allow_sleep_i |=> stay_awake_o)
        else $error("stay-awake dropped without permission");
    AST_SLEEP_CLR: assert property ((s_sel_idle ##0 allow_sleep_i) |=> !stay_awake_o)
        else $error("permission to sleep ignored");
endmodule : ssra_slave_sva

bind ssra_slave ssra_slave_sva chk_u (.*);

// >>> sim/ssra_master_model.sv
// ssra_master_model: behavioural four-wire master for the slave
// assumes a 125 ns link period and a pulled-up data-out line
`timescale 1ns/10ps
module ssra_master_model (
    output logic      sclk_o,
    output logic      cs_n_o,
    output logic      mosi_o,
    input  wire logic miso_i
);
    logic [7:0] txq[$];
    logic [7:0] rx_byte;
    event       got;
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        mosi_o = 1'b0;
    end
    // p is the parked clock level; bytes from index skip on are reported;
    // cut ends the frame after that many bits, -1 never
    task automatic xfer(input int skip, input logic p, input int cut);
        logic [7:0] b;
        int         n;
        int         k;
        n = 0;
        k = 0;
        // park the clock first so no edge lands with select
        sclk_o = p;
        #3.3 cs_n_o = 1'b0;
        while (txq.size() > 0 && n != cut) begin
            b = txq.pop_front();
            for (int i = 7; i >= 0 && n != cut; i--) begin
                #62.5 sclk_o = 1'b0;
                mosi_o = b[i];
                #62.5 sclk_o = 1'b1;
                rx_byte = {rx_byte[6:0], miso_i};
                n++;
            end
            if (k >= skip) -> got;
            k++;
        end
        #62.5 sclk_o = p;
        #31.25 cs_n_o = 1'b1;
        // released line must not look like a held bit
        mosi_o = ~mosi_o;
        txq.delete();
        #250;
    endtask : xfer
endmodule : ssra_master_model

// >>> sim/test_ssra_slave.sv
// test_ssra_slave: self-checking bench for the serial register slave
// assumes a pulled-up data-out line and a byte register file in the bench
`timescale 1ns/10ps
module test_ssra_slave;
    import ssra_pkg::*;
    logic            ref_clk_i;
    logic            resetn_i;
    logic            ce_i;
    logic            init_done_i;
    logic            awake_i;
    logic            allow_sleep_i;
    ssra_byte_t      reg_rd_data_i;
    wire logic       spi_clk_i, spi_cs_n_i, serial_in_pin_i;
    wire logic       serial_out_o, serial_out_oe_n_o, wake_req_o;
    wire logic       stay_awake_o, reg_rd_o, reg_wr_o;
    wire ssra_addr_t reg_addr_o;
    wire ssra_byte_t reg_wdata_o;
    wire logic       miso_w = serial_out_oe_n_o ? 1'b1 : serial_out_o;
    ssra_byte_t      mem [0:16383];
    logic [21:0]     exp_wr[$];
    ssra_byte_t      exp_rd[$];
    ssra_addr_t      st [4];
    int fails = 0;
    int samples_checked = 0;
    int cycles = 0;
    int nrd = 0;
    int nwake = 0;
    int n0, n1, seed;

    ssra_slave dut_u (.*);
    ssra_master_model m_u (
        .sclk_o (spi_clk_i),
        .cs_n_o (spi_cs_n_i),
        .mosi_o (serial_in_pin_i),
        .miso_i (miso_w)
    );

    initial begin
        ref_clk_i = 1'b0;
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end

    task automatic check(input logic [21:0] seen, input logic [21:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic give_verdict();
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : give_verdict

    function automatic ssra_addr_t nxt(ssra_addr_t a, logic [1:0] d);
        return d == DIR_FIX ? a : (d == DIR_DEC ? a - 14'h1 : a + 14'h1);
    endfunction : nxt

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
        #2;
    endtask : tick

    task automatic hdr(input ssra_byte_t c, input logic [1:0] d,
                       input ssra_addr_t a);
        m_u.txq.push_back(c);
        m_u.txq.push_back({d, a[13:8]});
        m_u.txq.push_back(a[7:0]);
    endtask : hdr

    task automatic wr(input logic [1:0] d, input ssra_addr_t a, input int n);
        ssra_byte_t v;
        hdr(INSTR_WRITE, d, a);
        repeat (n) begin
            v = ssra_byte_t'($random(seed));
            m_u.txq.push_back(v);
            exp_wr.push_back({a, v});
            a = nxt(a, d);
        end
        m_u.xfer(99, d[0], -1);
    endtask : wr

    task automatic rd(input logic [1:0] d, input ssra_addr_t a, input int n);
        hdr(INSTR_READ, d, a);
        m_u.txq.push_back(ssra_byte_t'($random(seed)));
        repeat (n) begin
            m_u.txq.push_back(ssra_byte_t'($random(seed)));
            exp_rd.push_back(mem[a]);
            a = nxt(a, d);
        end
        m_u.xfer(4, d[1], -1);
    endtask : rd

    // frame the slave must not serve; e is what the pin shows meanwhile
    task automatic ign(input ssra_byte_t c, input ssra_byte_t e,
                       input logic p);
        hdr(c, DIR_INC, 14'h0020);
        repeat (3) begin
            m_u.txq.push_back(ssra_byte_t'($random(seed)));
            exp_rd.push_back(e);
        end
        m_u.xfer(3, p, -1);
    endtask : ign

    // outputs are looked at once settled, never in the launching step
    always @(posedge ref_clk_i) begin : rd_port
        #2;
        if (reg_rd_o === 1'b1) reg_rd_data_i = mem[reg_addr_o];
    end

    // an access nobody asked for gets a note that cannot match
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            give_verdict();
        end
        #2;
        nrd += (reg_rd_o === 1'b1);
        nwake += (wake_req_o === 1'b1);
        if (reg_wr_o === 1'b1) begin
            if (exp_wr.size() == 0) exp_wr.push_back(~{reg_addr_o, reg_wdata_o});
            check({reg_addr_o, reg_wdata_o}, exp_wr.pop_front());
            mem[reg_addr_o] = reg_wdata_o;
        end
    end

    always @(m_u.got) begin
        if (exp_rd.size() == 0) exp_rd.push_back(~m_u.rx_byte);
        check(m_u.rx_byte, exp_rd.pop_front());
    end

    initial begin
        seed = 98407;
        ce_i = 1'b1;
        init_done_i = 1'b0;
        awake_i = 1'b1;
        allow_sleep_i = 1'b0;
        reg_rd_data_i = 8'h00;
        resetn_i = 1'b0;
        foreach (mem[i]) mem[i] = ssra_byte_t'($random(seed));
        tick(3);
        resetn_i = 1'b1;
        ign(INSTR_WRITE, 8'hFF, 1'b0);
        fork
            ign(INSTR_WRITE, 8'hFF, 1'b1);
            begin
                tick(60);
                init_done_i = 1'b1;
            end
        join
        $display("end: start-up gating");
        rd(DIR_FIX, 14'h0000, 1);
        st = '{14'h3FFE, 14'h3FFF, 14'h0001, 14'h1234};
        for (int d = 0; d < 4; d++) wr(2'(d), st[d], 3);
        for (int d = 0; d < 4; d++) rd(2'(d), st[d], 3);
        $display("end: bursts in all directions");
        hdr(INSTR_WRITE, DIR_INC, 14'h0100);
        m_u.txq.push_back(8'hC3);
        m_u.xfer(99, 1'b0, 28);
        $display("end: partial write");
        n0 = nrd;
        ign(8'h03, 8'hFF, 1'b0);
        check(22'(nrd), 22'(n0));
        $display("end: reserved instruction");
        allow_sleep_i = 1'b1;
        tick(1);
        allow_sleep_i = 1'b0;
        tick(2);
        check(stay_awake_o, 1'b0);
        awake_i = 1'b0;
        n1 = nwake;
        ign(INSTR_READ, 8'h00, 1'b1);
        check(22'(nwake), 22'(n1 + 1));
        check(22'(nrd), 22'(n0));
        check(stay_awake_o, 1'b1);
        awake_i = 1'b1;
        tick(1);
        rd(DIR_INC, 14'h0040, 2);
        tick(20);
        $display("end: wake and sleep");
        give_verdict();
    end
endmodule : test_ssra_slave
